// ===== fmsp_serial_port.sv
// Overview of operation
// - Full duplex, buffered rx; second frame lost while ri is still set.
// - Buffer write loads transmitter; buffer read returns separate rx register.
// - Mode 0 shifts 8 bits LSB first on rxd; txd is clock/12.
// - Mode 1 frame: start 0, 8 data LSB first, stop 1; stop to rx9.
// - Modes 2/3 frame: start, 8 data, tx9 bit, stop; rx9 gets ninth.
// - Mode 2 bit rate is clock/32 or clock/64.
// - Mode 3 same frame as mode 2 with variable bit rate.
// - A buffer write starts a transmission in every mode if that mode's engine is idle.
// - Mode 0 rx starts when ri 0 and ren 1; else on start bit.
// - Modes 2/3 with multiproc set: no rx flag if ninth bit is 0.
// - Mode 1 with multiproc set: no rx flag without valid stop bit.
// - Tx flag set after 8th bit in mode 0, stop start otherwise.
// - Rx flag set after 8th bit in mode 0, mid stop otherwise.
// - Ren and tx9 are software bits; tx9 used in modes 2/3 only.
// - Control register at 98H with mode, mp, ren, tx9, rx9, ti, ri.
// - Mode bits: 00 shift, 01 8-bit, 10 9-bit fixed, 11 9-bit variable.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module fmsp_serial_port
  import fmsp_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire fmsp_bus_t bus_req,
  output logic [7:0] rdata_q,
  input wire logic baud_tick,
  input wire logic rxd_in,
  output logic rxd_out_q,
  output logic rxd_oe_q,
  output logic txd_q,
  output logic irq_q
);

  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] rx_buf_q;
  logic [2:0] stat_q, stat_d, mask_q;
  logic [0:0] cfg_q;
  fmsp_mode_t mode;
  logic wr_ctrl, wr_buf, rd_buf, rd_stat, wr_mask, wr_cfg;
  logic [1:0] fix_div_q;
  logic os_tick;
  logic m0_busy_q, m0_dir_tx_q;
  logic [3:0] m0_ph_q;
  logic [2:0] m0_bit_q;
  logic [7:0] m0_sr_q;
  logic m0_end, m0_tx_done, m0_rx_done;
  logic atx_busy_q;
  logic [10:0] atx_sr_q;
  logic [3:0] atx_bits_q, atx_os_q;
  logic atx_bit_end, atx_ti;
  fmsp_rx_state_t arx_state_q;
  logic [3:0] arx_os_q, arx_cnt_q;
  logic [9:0] arx_sr_q, arx_nxt;
  logic rxd_prev_q;
  logic arx_sample, arx_end, rx_ninth, rx_accept, rx_load;
  logic [7:0] rx_data;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  function automatic logic hit(input fmsp_bus_t b, input logic [7:0] off);
    return b.addr == off;
  endfunction

  assign mode = fmsp_mode_t'(ctrl_q[CTL_MODE_HI:CTL_MODE_LO]);
  assign wr_ctrl = bus_req.wr && hit(bus_req, CTRL_OFF);
  assign wr_buf = bus_req.wr && hit(bus_req, BUF_OFF);
  assign rd_buf = bus_req.rd && hit(bus_req, BUF_OFF);
  assign rd_stat = bus_req.rd && hit(bus_req, IRQ_STAT_OFF);
  assign wr_mask = bus_req.wr && hit(bus_req, IRQ_MASK_OFF);
  assign wr_cfg = bus_req.wr && hit(bus_req, CFG_OFF);

  // Oversample tick: fixed fraction in mode 2, external timer otherwise
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fix_div_q <= 2'h0;
    end else begin
      fix_div_q <= fix_div_q + 2'h1;
    end
  end

  always_comb begin
    if (mode == MODE_UART9_FIX) begin
      os_tick = cfg_q[CFG_DOUBLE] ? fix_div_q[0]
                                  : (fix_div_q == FIX_SLOW_LAST);
    end else begin
      os_tick = baud_tick;
    end
  end

  fast_rate_a: assert property (
    os_tick && mode == MODE_UART9_FIX && cfg_q[CFG_DOUBLE]
    ##1 (mode == MODE_UART9_FIX && cfg_q[CFG_DOUBLE])[*2]
    |-> os_tick && !$past(os_tick))
    else $error("mode 2 fast tick not every 2 cycles");
  slow_rate_a: assert property (
    os_tick && mode == MODE_UART9_FIX && !cfg_q[CFG_DOUBLE]
    ##1 (mode == MODE_UART9_FIX && !cfg_q[CFG_DOUBLE])[*4]
    |-> os_tick && !$past(os_tick, 1) && !$past(os_tick, 2)
    && !$past(os_tick, 3))
    else $error("mode 2 slow tick not every 4 cycles");

  // Mode 0 shift engine, shared by both directions on one pin pair
  assign m0_end = m0_busy_q && m0_ph_q == M0_PH_LAST
                  && m0_bit_q == M0_BIT_LAST;
  assign m0_tx_done = m0_end && m0_dir_tx_q;
  assign m0_rx_done = m0_end && !m0_dir_tx_q;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      m0_busy_q <= 1'b0;
      m0_dir_tx_q <= 1'b0;
      m0_ph_q <= 4'h0;
      m0_bit_q <= 3'h0;
      m0_sr_q <= 8'h00;
    end else if (!m0_busy_q) begin
      m0_ph_q <= 4'h0;
      m0_bit_q <= 3'h0;
      if (mode == MODE_SHIFT && wr_buf) begin
        m0_busy_q <= 1'b1;
        m0_dir_tx_q <= 1'b1;
        m0_sr_q <= bus_req.wdata;
      end else if (mode == MODE_SHIFT && ctrl_q[CTL_REN]
                   && !ctrl_q[CTL_RI]) begin
        m0_busy_q <= 1'b1;
        m0_dir_tx_q <= 1'b0;
      end
    end else if (m0_ph_q == M0_PH_LAST) begin
      m0_ph_q <= 4'h0;
      m0_bit_q <= m0_bit_q + 3'h1;
      m0_sr_q <= {m0_dir_tx_q ? 1'b0 : rxd_in, m0_sr_q[7:1]};
      if (m0_bit_q == M0_BIT_LAST) begin
        m0_busy_q <= 1'b0;
      end
    end else begin
      m0_ph_q <= m0_ph_q + 4'h1;
    end
  end

  m0_rx_start_a: assert property (
    mode == MODE_SHIFT && !m0_busy_q && ctrl_q[CTL_REN] && !ctrl_q[CTL_RI]
    && !wr_buf |=> m0_busy_q && !m0_dir_tx_q)
    else $error("mode 0 reception did not start");

  sequence m0_clk_low_s;
    (!txd_q)[*6];
  endsequence
  sequence m0_clk_high_s;
    txd_q[*6];
  endsequence
  m0_shift_clk_a: assert property (
    m0_busy_q && m0_ph_q == 4'h0 |=> m0_clk_low_s ##1 m0_clk_high_s)
    else $error("mode 0 shift clock not 6 low 6 high");

  // Asynchronous transmitter
  assign atx_bit_end = atx_busy_q && os_tick && atx_os_q == OS_LAST;
  assign atx_ti = atx_bit_end && atx_bits_q == 4'h2;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      atx_busy_q <= 1'b0;
      atx_sr_q <= 11'h7ff;
      atx_bits_q <= 4'h0;
      atx_os_q <= 4'h0;
    end else if (!atx_busy_q) begin
      atx_os_q <= 4'h0;
      if (mode != MODE_SHIFT && wr_buf) begin
        atx_busy_q <= 1'b1;
        if (mode == MODE_UART8) begin
          atx_sr_q <= {2'b11, bus_req.wdata, 1'b0};
          atx_bits_q <= FRAME8_BITS;
        end else begin
          atx_sr_q <= {1'b1, ctrl_q[CTL_TX9], bus_req.wdata, 1'b0};
          atx_bits_q <= FRAME9_BITS;
        end
      end
    end else if (os_tick) begin
      atx_os_q <= atx_os_q + 4'h1;
      if (atx_os_q == OS_LAST) begin
        atx_sr_q <= {1'b1, atx_sr_q[10:1]};
        atx_bits_q <= atx_bits_q - 4'h1;
        if (atx_bits_q == 4'h1) begin
          atx_busy_q <= 1'b0;
        end
      end
    end
  end

  tx_start_bit_a: assert property (
    wr_buf && mode != MODE_SHIFT && !atx_busy_q && !m0_busy_q
    |-> ##2 !txd_q)
    else $error("no start bit after buffer write");
  stop_bit_high_a: assert property (
    atx_busy_q && atx_bits_q == 4'h1 |=> txd_q)
    else $error("stop bit not high");

  // Serial pins
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      txd_q <= 1'b1;
      rxd_out_q <= 1'b1;
      rxd_oe_q <= 1'b0;
    end else begin
      if (m0_busy_q) begin
        txd_q <= m0_ph_q >= M0_HALF;
      end else if (atx_busy_q) begin
        txd_q <= atx_sr_q[0];
      end else begin
        txd_q <= 1'b1;
      end
      rxd_oe_q <= m0_busy_q && m0_dir_tx_q;
      rxd_out_q <= m0_busy_q && m0_dir_tx_q ? m0_sr_q[0] : 1'b1;
    end
  end

  // Asynchronous receiver
  assign arx_sample = arx_state_q == RX_DATA && os_tick
                      && arx_os_q == OS_LAST;
  assign arx_nxt = {rxd_in, arx_sr_q[9:1]};
  assign arx_end = arx_sample && arx_cnt_q ==
                   (mode == MODE_UART8 ? RX8_SAMPLES : RX9_SAMPLES) - 4'h1;
  assign rx_ninth = mode == MODE_UART8 ? arx_nxt[9] : arx_nxt[8];
  assign rx_data = mode == MODE_UART8 ? arx_nxt[8:1] : arx_nxt[7:0];
  // Multiproc filter: stop bit in mode 1, ninth bit in modes 2 and 3
  assign rx_accept = arx_end
                     && !(ctrl_q[CTL_MP_EN] && !rx_ninth);
  assign rx_load = rx_accept && !ctrl_q[CTL_RI];

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      arx_state_q <= RX_IDLE;
      arx_os_q <= 4'h0;
      arx_cnt_q <= 4'h0;
      arx_sr_q <= 10'h000;
      rxd_prev_q <= 1'b1;
    end else begin
      rxd_prev_q <= rxd_in;
      unique case (arx_state_q)
        RX_IDLE: begin
          arx_os_q <= 4'h0;
          arx_cnt_q <= 4'h0;
          if (mode != MODE_SHIFT && ctrl_q[CTL_REN] && rxd_prev_q
              && !rxd_in) begin
            arx_state_q <= RX_START;
          end
        end
        RX_START: begin
          if (os_tick) begin
            arx_os_q <= arx_os_q + 4'h1;
            if (arx_os_q == OS_MID) begin
              arx_os_q <= 4'h0;
              arx_state_q <= rxd_in ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (os_tick) begin
            arx_os_q <= arx_os_q + 4'h1;
          end
          if (arx_sample) begin
            arx_sr_q <= arx_nxt;
            arx_cnt_q <= arx_cnt_q + 4'h1;
          end
          if (arx_end) begin
            arx_state_q <= RX_IDLE;
          end
        end
        default: begin
          arx_state_q <= RX_IDLE;
        end
      endcase
    end
  end

  rx_disabled_a: assert property (
    arx_state_q == RX_IDLE && !ctrl_q[CTL_REN] |=> arx_state_q == RX_IDLE)
    else $error("reception started with receive disabled");

  // Receive register, separate from the transmit path
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_buf_q <= 8'h00;
    end else if (rx_load) begin
      rx_buf_q <= rx_data;
    end else if (m0_rx_done) begin
      rx_buf_q <= {rxd_in, m0_sr_q[7:1]};
    end
  end

  rx_loaded_a: assert property (
    rx_load |=> rx_buf_q == $past(rx_data))
    else $error("receive register not loaded");
  mp_filter_a: assert property (
    arx_end && ctrl_q[CTL_MP_EN] && !rx_ninth
    |=> $stable(rx_buf_q) && !$rose(ctrl_q[CTL_RI]))
    else $error("filtered frame raised the receive flag");

  // Control register; hardware set wins over a software clear
  always_comb begin
    ctrl_d = wr_ctrl ? bus_req.wdata : ctrl_q;
    if (m0_tx_done || atx_ti) begin
      ctrl_d[CTL_TI] = 1'b1;
    end
    if (m0_rx_done) begin
      ctrl_d[CTL_RI] = 1'b1;
    end
    if (rx_load) begin
      ctrl_d[CTL_RI] = 1'b1;
      ctrl_d[CTL_RX9] = rx_ninth;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  ti_sticky_a: assert property (
    ctrl_q[CTL_TI] && !wr_ctrl |=> ctrl_q[CTL_TI])
    else $error("transmit flag cleared without software");
  ti_set_a: assert property (
    atx_ti |=> ctrl_q[CTL_TI] ##1 txd_q)
    else $error("transmit flag not set at stop bit start");
  rx9_store_a: assert property (
    rx_load |=> ctrl_q[CTL_RX9] == $past(rx_ninth))
    else $error("ninth bit not stored");

  // Interrupt status, mask and config
  always_comb begin
    stat_d = rd_stat ? 3'h0 : stat_q;
    stat_d[EV_TX] = stat_d[EV_TX] | m0_tx_done | atx_ti;
    stat_d[EV_RX] = stat_d[EV_RX] | m0_rx_done | rx_load;
    stat_d[EV_OVR] = stat_d[EV_OVR] | (rx_accept && ctrl_q[CTL_RI]);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stat_q <= 3'h0;
      mask_q <= MASK_RST;
      cfg_q <= CFG_RST;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      if (wr_mask) begin
        mask_q <= bus_req.wdata[EV_W-1:0];
      end
      if (wr_cfg) begin
        cfg_q <= bus_req.wdata[CFG_DOUBLE];
      end
      irq_q <= |(stat_q & mask_q);
    end
  end

  overrun_a: assert property (
    rx_accept && ctrl_q[CTL_RI] |=> stat_q[EV_OVR] && $stable(rx_buf_q))
    else $error("lost frame not reported");

  // Read port, data valid only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        CTRL_OFF: rdata_q <= ctrl_q;
        BUF_OFF: rdata_q <= rx_buf_q;
        IRQ_STAT_OFF: rdata_q <= {5'h00, stat_q};
        IRQ_MASK_OFF: rdata_q <= {5'h00, mask_q};
        CFG_OFF: rdata_q <= {7'h00, cfg_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Buffer read has no side effect on the receiver
  logic unused_rd_buf;
  assign unused_rd_buf = rd_buf;

endmodule

// ===== fmsp_pkg.sv
package fmsp_pkg;
  // Register offsets
  localparam logic [7:0] CTRL_OFF = 8'h98;
  localparam logic [7:0] BUF_OFF = 8'h99;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h9a;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h9b;
  localparam logic [7:0] CFG_OFF = 8'h9c;
  // Control register fields
  localparam int unsigned CTL_MODE_HI = 7;
  localparam int unsigned CTL_MODE_LO = 6;
  localparam int unsigned CTL_MP_EN = 5;
  localparam int unsigned CTL_REN = 4;
  localparam int unsigned CTL_TX9 = 3;
  localparam int unsigned CTL_RX9 = 2;
  localparam int unsigned CTL_TI = 1;
  localparam int unsigned CTL_RI = 0;
  // Interrupt status, mask and config fields
  localparam int unsigned EV_TX = 0;
  localparam int unsigned EV_RX = 1;
  localparam int unsigned EV_OVR = 2;
  localparam int unsigned EV_W = 3;
  localparam int unsigned CFG_DOUBLE = 0;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [0:0] CFG_RST = 1'h0;
  // Timing counts
  localparam logic [3:0] M0_PH_LAST = 4'hb;
  localparam logic [3:0] M0_HALF = 4'h6;
  localparam logic [2:0] M0_BIT_LAST = 3'h7;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [1:0] FIX_SLOW_LAST = 2'h3;
  localparam logic [3:0] FRAME8_BITS = 4'ha;
  localparam logic [3:0] FRAME9_BITS = 4'hb;
  localparam logic [3:0] RX8_SAMPLES = 4'h9;
  localparam logic [3:0] RX9_SAMPLES = 4'ha;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_UART8 = 2'b01,
    MODE_UART9_FIX = 2'b10,
    MODE_UART9_VAR = 2'b11
  } fmsp_mode_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10
  } fmsp_rx_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fmsp_bus_t;
endpackage

// ===== fmsp_remote_dev.sv
`timescale 1ns/1ps
module fmsp_remote_dev (
  input wire logic core_clk,
  input wire logic txd,
  input wire logic send,
  input wire logic [10:0] frame,
  input wire logic [3:0] nbits,
  input wire logic [7:0] bit_cyc,
  output logic line_q,
  output logic [10:0] got_q,
  output logic [7:0] got_cnt_q
);
  // Frame word goes out LSB first, start in bit 0, idle high
  initial begin
    line_q = 1'b1;
    forever begin
      @(posedge core_clk);
      if (send) begin
        for (int i = 0; i < nbits; i++) begin
          line_q <= frame[i];
          repeat (bit_cyc) @(posedge core_clk);
        end
        line_q <= 1'b1;
      end
    end
  end
  // Bit centres sampled from the start edge on
  initial begin
    got_cnt_q = 8'h00;
    forever begin
      @(negedge txd);
      got_q = 11'h000;
      repeat (bit_cyc / 2) @(posedge core_clk);
      for (int i = 0; i < nbits; i++) begin
        got_q[i] = txd;
        repeat (bit_cyc) @(posedge core_clk);
      end
      got_cnt_q = got_cnt_q + 8'h01;
    end
  end
endmodule

// ===== fmsp_serial_port_tb_top.sv
`timescale 1ns/1ps
module fmsp_serial_port_tb_top
  import fmsp_pkg::*;
;
  logic core_clk, nrst, baud_tick, rxd_pin, m0_on, m0_bit, dev_send, n9;
  logic rxd_out_q, rxd_oe_q, txd_q, irq_q, dev_line;
  logic [7:0] rdata_q, dev_cyc, dev_cnt, v, d, r, e;
  logic [10:0] dev_frame, dev_got;
  logic [3:0] dev_nbits;
  logic [1:0] tcnt;
  fmsp_bus_t bus_req;
  int n_fail, cmp_count;
  time t0;

  fmsp_serial_port DUT (.core_clk(core_clk), .nrst(nrst),
    .bus_req(bus_req), .rdata_q(rdata_q), .baud_tick(baud_tick),
    .rxd_in(rxd_pin), .rxd_out_q(rxd_out_q), .rxd_oe_q(rxd_oe_q),
    .txd_q(txd_q), .irq_q(irq_q));
  fmsp_remote_dev dev (.core_clk(core_clk), .txd(txd_q), .send(dev_send),
    .frame(dev_frame), .nbits(dev_nbits), .bit_cyc(dev_cyc),
    .line_q(dev_line), .got_q(dev_got), .got_cnt_q(dev_cnt));
  // Mode 0 transmit owns the pin, else the far side
  assign rxd_pin = rxd_oe_q ? rxd_out_q : (m0_on ? m0_bit : dev_line);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Tick every 4 clocks, so one bit is 64 clocks
  always @(posedge core_clk) begin
    tcnt <= tcnt + 2'h1;
    baud_tick <= (tcnt == 2'h3);
  end

  task automatic finish_test();
    $display("fails %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [10:0] g, input logic [10:0] x);
    cmp_count++;
    if (g !== x) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 chk({3'h0, rdata_q}, {3'h0, x});
  endtask

  task automatic send(input logic [10:0] f, input logic [3:0] n);
    @(posedge core_clk);
    dev_frame <= f;
    dev_nbits <= n;
    dev_send <= 1'b1;
    @(posedge core_clk);
    dev_send <= 1'b0;
    repeat (int'(n) * 64 + 40) @(posedge core_clk);
  endtask

  // Expected line bits, LSB first: start 0, data, then the top bits
  function automatic logic [10:0] exp_frame(input logic [7:0] b,
                                            input logic [1:0] top);
    return {top, b, 1'b0};
  endfunction

  task automatic tx_frame(input logic [7:0] b, input logic [10:0] x);
    v = dev_cnt;
    wr(BUF_OFF, b);
    for (int i = 0; i < 3000 && dev_cnt == v; i++) @(posedge core_clk);
    chk({3'h0, dev_cnt}, {3'h0, v + 8'h01});
    chk(dev_got, x);
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    finish_test();
  end

  initial begin
    void'($urandom(48512));
    nrst = 1'b0;
    bus_req = '0;
    tcnt = 2'h0;
    baud_tick = 1'b0;
    m0_on = 1'b0;
    m0_bit = 1'b1;
    dev_send = 1'b0;
    dev_frame = '0;
    dev_nbits = 4'ha;
    dev_cyc = 8'h40;
    n_fail = 0;
    cmp_count = 0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    rd(CTRL_OFF, CTRL_RST);
    rd(IRQ_MASK_OFF, 8'h00);
    rd(8'h50, 8'h00);
    wr(CTRL_OFF, 8'h50);
    d = 8'($urandom);
    r = 8'($urandom);
    fork
      send(exp_frame(r, 2'h1), 4'ha);
      tx_frame(d, exp_frame(d, 2'h1));
    join
    chk(irq_q, 1'b0);
    wr(IRQ_MASK_OFF, 8'h07);
    repeat (3) @(posedge core_clk);
    chk(irq_q, 1'b1);
    rd(IRQ_STAT_OFF, 8'h03);
    repeat (3) @(posedge core_clk);
    chk(irq_q, 1'b0);
    rd(CTRL_OFF, 8'h57);
    rd(BUF_OFF, r);
    send({2'h1, ~r, 1'b0}, 4'ha);
    rd(BUF_OFF, r);
    rd(IRQ_STAT_OFF, 8'h04);
    wr(CTRL_OFF, 8'h40);
    send({2'h1, r, 1'b0}, 4'ha);
    rd(CTRL_OFF, 8'h40);
    for (int i = 0; i < 4; i++) begin
      n9 = i[0];
      e = i[1] ? 8'hf0 : 8'h70;
      wr(CTRL_OFF, e);
      send({i[1], n9, r, 1'b0}, i[1] ? 4'hb : 4'ha);
      rd(CTRL_OFF, e | (n9 ? 8'h05 : 8'h00));
    end
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      n9 = d[7];
      e = {(i == 2) ? 2'h3 : 2'h2, 2'h0, n9, 3'h0};
      wr(CFG_OFF, {7'h00, i == 1});
      wr(CTRL_OFF, e);
      dev_cyc <= (i == 1) ? 8'h20 : 8'h40;
      dev_nbits <= 4'hb;
      tx_frame(d, exp_frame(d, {1'b1, n9}));
      rd(CTRL_OFF, e | 8'h02);
    end
    wr(CFG_OFF, 8'h00);
    wr(CTRL_OFF, 8'h00);
    d = 8'($urandom);
    wr(BUF_OFF, d);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd_q);
      #1;
      if (i == 0) t0 = $time;
      r[i] = rxd_out_q;
      chk(rxd_oe_q, 1'b1);
    end
    chk(11'($time - t0), 11'h2a0);
    chk(r, d);
    repeat (20) @(posedge core_clk);
    rd(CTRL_OFF, 8'h02);
    r = 8'($urandom);
    m0_on <= 1'b1;
    wr(CTRL_OFF, 8'h10);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd_q);
      m0_bit <= r[i];
    end
    repeat (20) @(posedge core_clk);
    rd(CTRL_OFF, 8'h11);
    rd(BUF_OFF, r);
    finish_test();
  end
endmodule
